// File: hw/srcfg_top.sv
// system reset cause flags, debug forced reset and write-once option register
`timescale 1ns/100ps

module srcfg_top
    import srcfg_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYC
)(
    input  wire logic       I_CLK,
    input  wire logic       I_RST,
    input  wire logic       I_WR,
    input  wire logic       I_WR_DEBUG,
    input  wire logic       I_RD,
    input  wire logic [1:0] I_SEL,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_ILLEGAL_ADDR,
    input  wire logic       I_SUPPLY_LOW,
    input  wire logic       I_DIP_RESET_EN,
    input  wire logic       I_STOP_EXEC,
    input  wire logic       I_OTHER_RESET,
    input  wire logic       I_WDOG_CLK_SEL,
    output logic      [7:0] O_RDATA,
    output logic            O_RD_VALID,
    output logic            O_SYS_RESET,
    output logic            O_ILLEGAL_OPCODE_RESET,
    output logic      [2:0] O_WDOG_PERIOD_SEL,
    output logic            O_STOP_PERMIT,
    output logic            O_TWO_WIRE_ON_PORT_B,
    output logic            O_DEBUG_PIN_ENABLE,
    output logic            O_RESET_PIN_ENABLE,
    output logic            O_RESET_PIN_PULLUP
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_RUN,
        ST_HOLD
    } srcfg_state_e;

    typedef struct packed {
        srcfg_state_e       state;
        logic [HOLD_W-1:0]  hold_cnt;
        logic               illegal_address_flag;
        logic               low_voltage_cause_flag;
        logic               opcode_rst;
        logic [1:0]         tmo;
        logic               stop_permit;
        logic               tw_sel;
        logic               dbg_pin;
        logic               rst_pin;
        logic               lock;
        logic               wdog_clk;
        logic [2:0]         low_sync;
        logic               low_lvl;
        logic [7:0]         rdata;
        logic               rd_valid;
    } srcfg_state_s;

    srcfg_state_s st_q;
    srcfg_state_s st_d;

    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);

    // ------------------------------------------------------------
    // decoded events
    // ------------------------------------------------------------
    logic any_wr;
    logic force_hit;
    logic dip_hit;
    logic stop_hit;
    logic addr_hit;
    logic opt_wr;
    logic start_rst;

    always_comb
    begin
        any_wr    = I_WR | I_WR_DEBUG;
        // only the debug path reaches the trigger bit
        force_hit = I_WR_DEBUG & (I_SEL == SEL_FORCE)
                  & I_WDATA[FORCE_TRIG_BIT];
        dip_hit   = st_q.low_lvl & I_DIP_RESET_EN;
        stop_hit  = I_STOP_EXEC & ~st_q.stop_permit;
        addr_hit  = I_ILLEGAL_ADDR;
        opt_wr    = any_wr & (I_SEL == SEL_OPT1) & ~st_q.lock;
        start_rst = force_hit | dip_hit | stop_hit | addr_hit | I_OTHER_RESET;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;

        // supply comparator is asynchronous: three stages, act on agreement
        // clock select comes from a register on this clock: no synchroniser needed
        st_d.wdog_clk = I_WDOG_CLK_SEL;
        st_d.low_sync = {st_q.low_sync[1:0], I_SUPPLY_LOW};
        if (st_q.low_sync[1] == st_q.low_sync[2])
        begin
            st_d.low_lvl = st_q.low_sync[2];
        end

        st_d.rd_valid = 1'b0;
        if (I_RD)
        begin
            st_d.rd_valid = 1'b1;
            unique case (I_SEL)
                SEL_CAUSE:
                begin
                    st_d.rdata                 = READ_ZERO;
                    st_d.rdata[CAUSE_ILLEGAL_ADDRESS_FLAG_BIT] = st_q.illegal_address_flag;
                    st_d.rdata[CAUSE_LVD_BIT]  = st_q.low_voltage_cause_flag;
                end
                SEL_FORCE:
                begin
                    st_d.rdata = READ_ZERO;
                end
                SEL_OPT1:
                begin
                    // readable at any time, locked or not
                    st_d.rdata                           = READ_ZERO;
                    st_d.rdata[OPT_TMO_HI:OPT_TMO_LO]    = st_q.tmo;
                    st_d.rdata[OPT_STOP_BIT]             = st_q.stop_permit;
                    st_d.rdata[OPT_TW_BIT]               = st_q.tw_sel;
                    st_d.rdata[OPT_DBG_BIT]              = st_q.dbg_pin;
                    st_d.rdata[OPT_RSTP_BIT]             = st_q.rst_pin;
                end
                default:
                begin
                    st_d.rdata = READ_ZERO;
                end
            endcase
        end

        unique case (st_q.state)
            ST_RUN:
            begin
                if (start_rst)
                begin
                    // cause flags are rewritten on reset entry, never cleared by software
                    st_d.state      = ST_HOLD;
                    st_d.hold_cnt   = '0;
                    st_d.illegal_address_flag       = addr_hit & ~force_hit;
                    st_d.low_voltage_cause_flag        = dip_hit & ~force_hit;
                    st_d.opcode_rst = stop_hit & ~force_hit;
                    // options back to defaults, reset pin config survives
                    st_d.tmo         = OPT_TMO_RST;
                    st_d.stop_permit = OPT_STOP_RST;
                    st_d.tw_sel      = OPT_TW_RST;
                    st_d.dbg_pin     = OPT_DBG_RST;
                    st_d.lock        = 1'b0;
                end
                else if (opt_wr)
                begin
                    st_d.tmo         = I_WDATA[OPT_TMO_HI:OPT_TMO_LO];
                    st_d.stop_permit = I_WDATA[OPT_STOP_BIT];
                    st_d.tw_sel      = I_WDATA[OPT_TW_BIT];
                    st_d.dbg_pin     = I_WDATA[OPT_DBG_BIT];
                    st_d.rst_pin     = I_WDATA[OPT_RSTP_BIT];
                    st_d.lock        = 1'b1;
                end
            end
            ST_HOLD:
            begin
                // requests are ignored while the reset is driven
                if (st_q.hold_cnt == HOLD_LAST)
                begin
                    st_d.state      = ST_RUN;
                    st_d.opcode_rst = 1'b0;
                end
                else
                begin
                    st_d.hold_cnt = st_q.hold_cnt + HOLD_W'(1);
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // the async reset is the power-on reset
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            st_q.state       <= ST_RUN;
            st_q.hold_cnt    <= '0;
            st_q.illegal_address_flag        <= ILLEGAL_ADDRESS_FLAG_POR;
            st_q.low_voltage_cause_flag         <= LVD_POR;
            st_q.opcode_rst  <= 1'b0;
            st_q.tmo         <= OPT_TMO_RST;
            st_q.stop_permit <= OPT_STOP_RST;
            st_q.tw_sel      <= OPT_TW_RST;
            st_q.dbg_pin     <= OPT_DBG_RST;
            st_q.rst_pin     <= OPT_RSTP_POR;
            st_q.lock        <= 1'b0;
            st_q.wdog_clk    <= 1'b0;
            st_q.low_sync    <= '0;
            st_q.low_lvl     <= 1'b0;
            st_q.rdata       <= READ_ZERO;
            st_q.rd_valid    <= 1'b0;
        end
        else
        begin
            // rst_pin is only ever rewritten by the first options write after power-on or after each internal reset
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb
    begin
        O_RDATA                = st_q.rdata;
        O_RD_VALID             = st_q.rd_valid;
        O_SYS_RESET            = (st_q.state == ST_HOLD);
        O_ILLEGAL_OPCODE_RESET = st_q.opcode_rst;
        O_WDOG_PERIOD_SEL      = {st_q.wdog_clk, st_q.tmo};
        O_STOP_PERMIT          = st_q.stop_permit;
        O_TWO_WIRE_ON_PORT_B   = st_q.tw_sel;
        O_DEBUG_PIN_ENABLE     = st_q.dbg_pin;
        O_RESET_PIN_ENABLE     = st_q.rst_pin;
        O_RESET_PIN_PULLUP     = st_q.rst_pin;
    end

endmodule // srcfg_top

// File: hw/srcfg_pkg.sv
// constants shared by the system reset and option control block
package srcfg_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned RESET_HOLD_NS  = 100;
    // least time: round up, never below one cycle
    localparam int unsigned RESET_HOLD_RAW = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_RAW < 1) ? 1 : RESET_HOLD_RAW;
    localparam int unsigned HOLD_W         = 4;

    // ------------------------------------------------------------
    // register selects on the register access port
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_CAUSE = 2'h0;
    localparam logic [1:0] SEL_FORCE = 2'h1;
    localparam logic [1:0] SEL_OPT1  = 2'h2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CAUSE_ILLEGAL_ADDRESS_FLAG_BIT = 3;
    localparam int unsigned CAUSE_LVD_BIT  = 1;
    localparam int unsigned FORCE_TRIG_BIT = 0;
    localparam int unsigned OPT_TMO_HI     = 7;
    localparam int unsigned OPT_TMO_LO     = 6;
    localparam int unsigned OPT_STOP_BIT   = 5;
    localparam int unsigned OPT_TW_BIT     = 2;
    localparam int unsigned OPT_DBG_BIT    = 1;
    localparam int unsigned OPT_RSTP_BIT   = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] READ_ZERO      = 8'h00;
    localparam logic [1:0] OPT_TMO_RST    = 2'h3;
    localparam logic       OPT_STOP_RST   = 1'h0;
    localparam logic       OPT_TW_RST     = 1'h0;
    localparam logic       OPT_DBG_RST    = 1'h1;
    localparam logic       OPT_RSTP_POR   = 1'h0;
    localparam logic       LVD_POR        = 1'h1;
    localparam logic       ILLEGAL_ADDRESS_FLAG_POR       = 1'h0;

endpackage : srcfg_pkg

// File: bench/srcfg_props.sv
// assertion checker for the reset and option control block
`timescale 1ns/100ps
module srcfg_props
    import srcfg_pkg::*;
#(parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYC)
(
    input wire logic       I_CLK, I_RST, I_WR, I_WR_DEBUG, I_RD, I_ILLEGAL_ADDR,
    input wire logic       I_SUPPLY_LOW, I_STOP_EXEC, I_OTHER_RESET,
    input wire logic [1:0] I_SEL,
    input wire logic [7:0] I_WDATA, O_RDATA,
    input wire logic       O_SYS_RESET, O_ILLEGAL_OPCODE_RESET, O_STOP_PERMIT,
    input wire logic       O_DEBUG_PIN_ENABLE, O_RESET_PIN_ENABLE,
    input wire logic [2:0] O_WDOG_PERIOD_SEL
);
    logic [7:0] hold_q;
    logic [7:0] hold_d;
    // counts high cycles so the hold length is checked without long repetition
    always_comb hold_d = O_SYS_RESET ? hold_q + 8'h01 : 8'h00;
    always_ff @(posedge I_CLK or posedge I_RST)
        if (I_RST) hold_q <= 8'h00;
        else hold_q <= hold_d;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    property p_force_rd; I_RD && I_SEL == SEL_FORCE |=> O_RDATA == READ_ZERO; endproperty
    a_force_rd: assert property (p_force_rd) else $error("force read not zero");
    property p_illegal_address_flag; I_ILLEGAL_ADDR && !O_SYS_RESET |=> O_SYS_RESET; endproperty
    a_illegal_address_flag: assert property (p_illegal_address_flag) else $error("no reset on bad address");
    property p_dbg; I_WR_DEBUG && I_SEL == SEL_FORCE && I_WDATA[FORCE_TRIG_BIT] && !O_SYS_RESET
        |=> O_SYS_RESET; endproperty
    a_dbg: assert property (p_dbg) else $error("debug force gave no reset");
    property p_user; I_WR && !I_WR_DEBUG && I_SEL == SEL_FORCE && !O_SYS_RESET
        && !(I_ILLEGAL_ADDR | I_OTHER_RESET | I_STOP_EXEC | I_SUPPLY_LOW)
        |=> !O_SYS_RESET; endproperty
    a_user: assert property (p_user) else $error("user force write acted");
    property p_stop; I_STOP_EXEC && !O_STOP_PERMIT && !O_SYS_RESET
        |=> O_SYS_RESET && O_ILLEGAL_OPCODE_RESET; endproperty
    a_stop: assert property (p_stop) else $error("stop not refused");
    property p_hold; $fell(O_SYS_RESET) |-> hold_q == HOLD_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("reset hold length wrong");
    property p_dflt; $rose(O_SYS_RESET) |-> O_WDOG_PERIOD_SEL[1:0] == OPT_TMO_RST
        && O_STOP_PERMIT == OPT_STOP_RST && O_DEBUG_PIN_ENABLE == OPT_DBG_RST; endproperty
    a_dflt: assert property (p_dflt) else $error("options not defaulted");
    property p_pin; O_RESET_PIN_ENABLE && O_SYS_RESET |=> O_RESET_PIN_ENABLE; endproperty
    a_pin: assert property (p_pin) else $error("reset pin lost");
endmodule // srcfg_props

bind srcfg_top srcfg_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.*);

// File: bench/srcfg_dbg_host.sv
// debug host model issuing background force-reset writes
`timescale 1ns/100ps
module srcfg_dbg_host
    import srcfg_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [7:0] i_data,
    output logic            o_wr = 1'b0,
    output logic      [1:0] o_sel = 2'h0,
    output logic      [7:0] o_wdata = 8'h00
);
    // only this path may reach the force register; idle data toggles, never holds
    // drives on the falling edge like the rest of the stimulus
    always @(negedge i_clk)
    begin
        o_wr <= i_go;
        o_sel <= i_go ? SEL_FORCE : ~o_sel;
        o_wdata <= i_go ? i_data : ~o_wdata;
    end
endmodule // srcfg_dbg_host

// File: bench/srcfg_bench.sv
// self-checking bench for the reset and option control block
`timescale 1ns/100ps
module srcfg_bench;
    import srcfg_pkg::*;
    logic I_CLK = 1'b0, I_RST = 1'b1, wr = 1'b0, rd = 1'b0, sup = 1'b0, den = 1'b0;
    logic wsel = 1'b0, go = 1'b0, opc, dwr, rv, srst, orst, stp, twb, dpe, rpe, rpu;
    logic [1:0] sel = 2'h0, dsel;
    logic [2:0] ev = 3'h0, wd;
    logic [7:0] wdata = 8'h00, ddat = 8'h01, dwd, rdata;
    int fail_count = 0, total_checks = 0;
    always #12.5 I_CLK = ~I_CLK;
    srcfg_top #(.HOLD_CYCLES(4)) dut_u (.I_CLK(I_CLK), .I_RST(I_RST), .I_WR(wr),
        .I_WR_DEBUG(dwr), .I_RD(rd), .I_SEL(dwr ? dsel : sel), .I_WDATA(dwr ? dwd : wdata),
        .I_ILLEGAL_ADDR(ev[0]), .I_SUPPLY_LOW(sup), .I_DIP_RESET_EN(den),
        .I_STOP_EXEC(ev[1]), .I_OTHER_RESET(ev[2]), .I_WDOG_CLK_SEL(wsel),
        .O_RDATA(rdata), .O_RD_VALID(rv), .O_SYS_RESET(srst), .O_ILLEGAL_OPCODE_RESET(orst),
        .O_WDOG_PERIOD_SEL(wd), .O_STOP_PERMIT(stp), .O_TWO_WIRE_ON_PORT_B(twb),
        .O_DEBUG_PIN_ENABLE(dpe), .O_RESET_PIN_ENABLE(rpe), .O_RESET_PIN_PULLUP(rpu));
    srcfg_dbg_host host_u (.i_clk(I_CLK), .i_go(go), .i_data(ddat), .o_wr(dwr),
        .o_sel(dsel), .o_wdata(dwd));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] a);
        total_checks++;
        if (a !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, a);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rrd(input logic [1:0] s, input logic [7:0] e);
        @(negedge I_CLK);
        rd = 1'b1;
        sel = s;
        @(negedge I_CLK);
        rd = 1'b0;
        chk("read valid", 8'h01, {7'h00, rv});
        chk("read data", e, rdata);
    endtask
    task automatic rwr(input logic [1:0] s, input logic [7:0] d);
        @(negedge I_CLK);
        wr = 1'b1;
        sel = s;
        wdata = d;
        @(negedge I_CLK);
        wr = 1'b0;
    endtask
    task automatic pulse(input logic [2:0] e);
        @(negedge I_CLK);
        ev = e;
        @(negedge I_CLK);
        ev = 3'h0;
    endtask
    // bounded wait for the internal reset to start and finish
    task automatic ride();
        int n;
        opc = 1'b0;
        for (n = 0; n < 10 && srst !== 1'b1; n++) @(negedge I_CLK);
        sup = 1'b0;
        for (n = 0; n < 10 && srst === 1'b1; n++)
        begin
            opc = opc | orst;
            @(negedge I_CLK);
        end
        if (srst !== 1'b0 || n == 0)
        begin
            chk("reset pulse", 8'h01, 8'h00);
            close_out();
        end
    endtask
    task automatic t_power_on();
        rrd(SEL_CAUSE, 8'h02);
        rrd(SEL_OPT1, 8'hc2);
        rrd(SEL_FORCE, 8'h00);
        rrd(2'h3, 8'h00);
        $display("done power_on");
    endtask
    task automatic t_write_once();
        wsel = 1'b1;
        rwr(SEL_OPT1, 8'h27);
        rwr(SEL_FORCE, 8'h01);
        rwr(SEL_OPT1, 8'hc0);
        chk("no reset", 8'h00, {7'h00, srst});
        rrd(SEL_OPT1, 8'h27);
        chk("outputs", 8'h9f, {wd, stp, twb, dpe, rpe, rpu});
        $display("done write_once");
    endtask
    task automatic t_illegal();
        pulse(3'h1);
        ride();
        rrd(SEL_CAUSE, 8'h08);
        rrd(SEL_OPT1, 8'hc3);
        pulse(3'h2);
        ride();
        chk("opcode reset", 8'h01, {7'h00, opc});
        rrd(SEL_CAUSE, 8'h00);
        rwr(SEL_OPT1, 8'h21);
        rrd(SEL_OPT1, 8'h21);
        pulse(3'h2);
        chk("stop allowed", 8'h00, {7'h00, srst});
        $display("done illegal");
    endtask
    task automatic t_dip_force();
        den = 1'b1;
        sup = 1'b1;
        ride();
        rrd(SEL_CAUSE, 8'h02);
        pulse(3'h4);
        ride();
        rrd(SEL_CAUSE, 8'h00);
        sup = 1'b1;
        ride();
        @(posedge I_CLK);
        go = 1'b1;
        @(posedge I_CLK);
        go = 1'b0;
        ride();
        rrd(SEL_CAUSE, 8'h00);
        $display("done dip_force");
    endtask
    initial
    begin
        repeat (20) @(posedge I_CLK);
        @(negedge I_CLK);
        I_RST = 1'b0;
        t_power_on();
        t_write_once();
        t_illegal();
        t_dip_force();
        close_out();
    end
endmodule // srcfg_bench
